/* logic/emu_cmd_params.svh */
// Constants for the legacy emulation command interpreter.
`ifndef EMU_CMD_PARAMS_SVH
`define EMU_CMD_PARAMS_SVH
`define SB_CHAN_BIT   7
`define SB_SRQ_BIT    6
`define SB_READY_BIT  5
`define SB_BUSY_BIT   4
`define SB_ERR_W      4
`define SET_W         12
`define SET_MAX       12'hE10
`define SET_RST       12'h000
`define NUM_CHAN      2
`endif

/* logic/emu_cmd_pkg.sv */
// Types shared by the legacy emulation command interpreter.
`include "emu_cmd_params.svh"
package emu_cmd_pkg;
  typedef enum logic [3:0] {
    CMD_LEARN,
    CMD_EMU_ENTRY,
    CMD_NATIVE,
    CMD_RECALL,
    CMD_CHAN_A,
    CMD_CHAN_B,
    CMD_VALUE_SEL,
    CMD_SET,
    CMD_INC,
    CMD_DEC,
    CMD_RESET,
    CMD_READY_CTL,
    CMD_ERROR_CTL
  } cmd_code_type;

  typedef enum logic {
    MODE_NATIVE,
    MODE_EMU
  } mode_type;

  typedef struct packed {
    cmd_code_type            code;
    logic                    arg;
    logic [`SET_W-1:0]       value;
  } cmd_type;

  typedef struct packed {
    logic                    chan_b;
    logic                    srq;
    logic                    ready;
    logic                    busy;
    logic [`SB_ERR_W-1:0]    err;
  } status_byte_type;

  typedef struct packed {
    mode_type                mode;
    logic                    chan_b;
    logic [`SET_W-1:0]       pend;
    logic [1:0][`SET_W-1:0]  setting;
    logic                    busy;
    logic                    ready_en;
    logic                    err_en;
    logic                    srq;
    logic                    err_nz;
    logic                    talk_valid;
    logic [`SET_W-1:0]       talk_value;
    logic                    flush;
    logic                    move_req;
    logic                    move_chan;
    logic [`SET_W-1:0]       move_value;
    logic                    chan_reset;
  } state_type;
endpackage

/* logic/legacy_emulation_command_status.sv */
// Legacy emulation command interpreter with emulated serial-poll status byte.
`timescale 1ns/1ns
`default_nettype none
`include "emu_cmd_params.svh"
module legacy_emulation_command_status
  import emu_cmd_pkg::*;
#(
  parameter int NUM_CHAN = `NUM_CHAN
)
(
  // Clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst,
  // Decoded commands from the bus front end
  input  wire logic                  i_cmd_valid,
  input  wire cmd_type               i_cmd,
  input  wire logic                  i_syntax_err,
  input  wire logic                  i_talk_addr,
  input  wire logic                  i_spoll_read,
  // Motion block
  input  wire logic                  i_move_done,
  input  wire logic [`SB_ERR_W-1:0]  i_err_code_a,
  input  wire logic [`SB_ERR_W-1:0]  i_err_code_b,
  // Status and outputs
  output status_byte_type            o_status,
  output logic                       o_srq,
  output logic                       o_emu_mode,
  output logic                       o_flush,
  output logic                       o_talk_valid,
  output logic [`SET_W-1:0]          o_talk_value,
  output logic                       o_move_req,
  output logic                       o_move_chan,
  output logic [`SET_W-1:0]          o_move_value,
  output logic                       o_chan_reset
);

  if (NUM_CHAN != 2) begin : g_chk
    $error("Only two channels are supported.");
  end

  state_type              st_r;
  state_type              st_nxt;
  logic [`SB_ERR_W-1:0]   sel_err;
  logic                   emu;
  logic                   ready_rise;
  logic                   err_rise;

  assign emu = (st_r.mode == MODE_EMU);
  assign sel_err = st_r.chan_b ? i_err_code_b : i_err_code_a;

  // A ready condition occurs when motion finishes; an error when the code turns non-zero.
  assign ready_rise = st_r.busy && i_move_done;
  assign err_rise = (sel_err != '0) && !st_r.err_nz;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.talk_valid = 1'b0;
    st_nxt.flush = 1'b0;
    st_nxt.move_req = 1'b0;
    st_nxt.chan_reset = 1'b0;
    st_nxt.err_nz = (sel_err != '0);
    if (i_move_done)
    begin
      st_nxt.busy = 1'b0;
    end
    // Poll read clears first so that a same-cycle event below sets it again.
    if (i_spoll_read)
    begin
      st_nxt.srq = 1'b0;
    end
    if (emu && ((st_r.ready_en && ready_rise) || (st_r.err_en && err_rise)))
    begin
      st_nxt.srq = 1'b1;
    end
    if (emu && i_syntax_err)
    begin
      st_nxt.flush = 1'b1;
    end
    if (emu && i_talk_addr)
    begin
      st_nxt.talk_valid = 1'b1;
      st_nxt.talk_value = st_r.setting[st_r.chan_b];
    end
    if (i_cmd_valid)
    begin
      case (i_cmd.code)
        CMD_LEARN, CMD_EMU_ENTRY:
        begin
          st_nxt.mode = MODE_EMU;
        end
        CMD_NATIVE:
        begin
          st_nxt.mode = MODE_NATIVE;
        end
        CMD_RECALL:
        begin
          st_nxt.mode = MODE_EMU;
        end
        default:
        begin
          if (emu && !st_r.busy)
          begin
            case (i_cmd.code)
              CMD_CHAN_A:
              begin
                st_nxt.chan_b = 1'b0;
              end
              CMD_CHAN_B:
              begin
                st_nxt.chan_b = 1'b1;
              end
              CMD_VALUE_SEL:
              begin
                st_nxt.pend = i_cmd.value;
              end
              CMD_SET:
              begin
                // An out-of-range setting falls back to the channel reset sequence.
                if (st_r.pend > `SET_MAX)
                begin
                  st_nxt.chan_reset = 1'b1;
                  st_nxt.setting[st_r.chan_b] = `SET_RST;
                  st_nxt.move_value = `SET_RST;
                end
                else
                begin
                  st_nxt.setting[st_r.chan_b] = st_r.pend;
                  st_nxt.move_value = st_r.pend;
                end
                st_nxt.move_req = 1'b1;
                st_nxt.move_chan = st_r.chan_b;
                st_nxt.busy = 1'b1;
              end
              CMD_INC, CMD_DEC:
              begin
                if (i_cmd.code == CMD_INC)
                begin
                  st_nxt.move_value = (st_r.setting[st_r.chan_b] >= `SET_MAX) ?
                    `SET_RST : st_r.setting[st_r.chan_b] + 12'h001;
                end
                else
                begin
                  st_nxt.move_value = (st_r.setting[st_r.chan_b] == `SET_RST) ?
                    `SET_MAX : st_r.setting[st_r.chan_b] - 12'h001;
                end
                st_nxt.setting[st_r.chan_b] = st_nxt.move_value;
                st_nxt.move_req = 1'b1;
                st_nxt.move_chan = st_r.chan_b;
                st_nxt.busy = 1'b1;
              end
              CMD_RESET:
              begin
                st_nxt.chan_reset = 1'b1;
                st_nxt.move_chan = st_r.chan_b;
                st_nxt.move_value = `SET_RST;
                st_nxt.setting[st_r.chan_b] = `SET_RST;
                st_nxt.busy = 1'b1;
              end
              CMD_READY_CTL:
              begin
                st_nxt.ready_en = i_cmd.arg;
              end
              CMD_ERROR_CTL:
              begin
                st_nxt.err_en = i_cmd.arg;
              end
              default:
              begin
                st_nxt.pend = st_r.pend;
              end
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // The status byte mirrors live state; it reads zero outside emulation.
  always_comb
  begin
    o_status = '0;
    if (emu)
    begin
      o_status.chan_b = st_r.chan_b;
      o_status.srq = st_r.srq;
      o_status.ready = !st_r.busy;
      o_status.busy = st_r.busy;
      o_status.err = sel_err;
    end
  end

  assign o_srq = st_r.srq;
  assign o_emu_mode = emu;
  assign o_flush = st_r.flush;
  assign o_talk_valid = st_r.talk_valid;
  assign o_talk_value = st_r.talk_value;
  assign o_move_req = st_r.move_req;
  assign o_move_chan = st_r.move_chan;
  assign o_move_value = st_r.move_value;
  assign o_chan_reset = st_r.chan_reset;

  property p_emu_entry;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_cmd_valid && (i_cmd.code == CMD_EMU_ENTRY || i_cmd.code == CMD_LEARN) |=> o_emu_mode;
  endproperty
  a_emu_entry: assert property (p_emu_entry) else $error("Entry did not select emulation.");

  property p_native;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_cmd_valid && i_cmd.code == CMD_NATIVE |=> !o_emu_mode && o_status == '0;
  endproperty
  a_native: assert property (p_native) else $error("Native command did not leave emulation.");

  property p_recall;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_cmd_valid && i_cmd.code == CMD_RECALL |=> o_emu_mode;
  endproperty
  a_recall: assert property (p_recall) else $error("Recall did not restore emulation.");

  property p_ready_busy;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_emu_mode |-> (o_status.ready != o_status.busy);
  endproperty
  a_ready_busy: assert property (p_ready_busy) else $error("Ready and busy bits agree.");

  property p_busy_move;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_move_req && !i_move_done |-> o_status.busy && !o_status.ready;
  endproperty
  a_busy_move: assert property (p_busy_move) else $error("Busy not shown during a move.");

  property p_err;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_emu_mode |-> o_status.err == (o_status.chan_b ? i_err_code_b : i_err_code_a);
  endproperty
  a_err: assert property (p_err) else $error("Error nibble not from selected channel.");

  property p_chan;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_emu_mode && !st_r.busy && i_cmd_valid && i_cmd.code == CMD_CHAN_B |=> o_status.chan_b;
  endproperty
  a_chan: assert property (p_chan) else $error("Channel B select not shown in bit 7.");

  property p_srq_bit;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_emu_mode && o_srq |-> o_status.srq;
  endproperty
  a_srq_bit: assert property (p_srq_bit) else $error("Request not reported in bit 6.");

  property p_reset_cmd;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_emu_mode && !st_r.busy && i_cmd_valid && i_cmd.code == CMD_RESET
        |=> o_chan_reset && o_move_chan == $past(st_r.chan_b) ##1 !o_chan_reset;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("Reset command not actioned.");

  property p_srq_cause;
    @(posedge i_ref_clk) disable iff (i_rst)
      $rose(o_srq) |-> $past(st_r.ready_en && ready_rise || st_r.err_en && err_rise);
  endproperty
  a_srq_cause: assert property (p_srq_cause) else $error("Request raised without cause.");

  property p_flush;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_emu_mode && i_syntax_err |=> o_flush ##1 (!o_flush || i_syntax_err);
  endproperty
  a_flush: assert property (p_flush) else $error("Syntax error did not flush.");

  property p_talk;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_emu_mode && i_talk_addr |=> o_talk_valid && o_talk_value == $past(st_r.setting[st_r.chan_b]);
  endproperty
  a_talk: assert property (p_talk) else $error("Talk value not the active setting.");

  // A mode command in the same cycle may clear the status, so it is left out.
  property p_ready_after;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_emu_mode && o_status.busy && i_move_done && !i_cmd_valid |=> o_status.ready;
  endproperty
  a_ready_after: assert property (p_ready_after) else $error("Ready not shown after a move.");

  property p_set;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_emu_mode && !st_r.busy && i_cmd_valid && i_cmd.code == CMD_SET && st_r.pend <= `SET_MAX
        |=> o_move_req && o_move_value == $past(st_r.pend);
  endproperty
  a_set: assert property (p_set) else $error("Set did not request the pending value.");

  property p_ready_ctl;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_emu_mode && !st_r.busy && i_cmd_valid && i_cmd.code == CMD_READY_CTL
        |=> st_r.ready_en == $past(i_cmd.arg);
  endproperty
  a_ready_ctl: assert property (p_ready_ctl) else $error("Ready request enable not taken.");

  property p_error_ctl;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_emu_mode && !st_r.busy && i_cmd_valid && i_cmd.code == CMD_ERROR_CTL
        |=> st_r.err_en == $past(i_cmd.arg);
  endproperty
  a_error_ctl: assert property (p_error_ctl) else $error("Error request enable not taken.");

  property p_ready_srq;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_emu_mode && st_r.ready_en && st_r.busy && i_move_done |=> o_srq;
  endproperty
  a_ready_srq: assert property (p_ready_srq) else $error("Ready request not raised.");

endmodule
`default_nettype wire

/* verif/motion_model.sv */
// Motion block model that answers move and channel reset requests.
`timescale 1ns/1ns
`default_nettype none
module motion_model
(
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  // Requests from the interpreter and the slow-answer select
  input  wire logic i_move_req,
  input  wire logic i_chan_reset,
  input  wire logic i_slow,
  // Completion
  output logic      o_move_done
);
  int unsigned cnt_r;
  // A slow answer widens the busy window so that refused commands fit inside it.
  always_ff @(posedge i_ref_clk)
  begin
    o_move_done <= 1'b0;
    if (i_rst)
    begin
      cnt_r <= 0;
    end
    else if (i_move_req || i_chan_reset)
    begin
      cnt_r <= i_slow ? 20 : 2;
    end
    else if (cnt_r == 1)
    begin
      cnt_r <= 0;
      o_move_done <= 1'b1;
    end
    else if (cnt_r != 0)
    begin
      cnt_r <= cnt_r - 1;
    end
  end
endmodule
`default_nettype wire

/* verif/test_legacy_emulation_command_status.sv */
// Self-checking testbench for the legacy emulation command interpreter.
`timescale 1ns/1ns
`default_nettype none
`include "emu_cmd_params.svh"
module test_legacy_emulation_command_status;
  import emu_cmd_pkg::*;
  typedef struct packed {cmd_code_type code; logic arg; logic [7:0] st; logic emu;} row_type;
  logic            i_ref_clk, i_rst, i_cmd_valid, i_syntax_err, i_talk_addr, i_spoll_read;
  logic            slow, o_srq, o_emu_mode, o_flush, o_talk_valid;
  logic            o_move_req, o_move_chan, o_chan_reset;
  logic [3:0]      err_a, err_b;
  logic [11:0]     o_talk_value, o_move_value;
  wire logic       move_done;
  cmd_type         i_cmd;
  status_byte_type o_status;
  int              bad_count, comparisons;
  row_type         rows [10];

  legacy_emulation_command_status u_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_syntax_err(i_syntax_err),
    .i_talk_addr(i_talk_addr), .i_spoll_read(i_spoll_read), .i_move_done(move_done),
    .i_err_code_a(err_a), .i_err_code_b(err_b), .o_status(o_status), .o_srq(o_srq),
    .o_emu_mode(o_emu_mode), .o_flush(o_flush), .o_talk_valid(o_talk_valid),
    .o_talk_value(o_talk_value), .o_move_req(o_move_req), .o_move_chan(o_move_chan),
    .o_move_value(o_move_value), .o_chan_reset(o_chan_reset));
  motion_model u_motion (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_move_req(o_move_req),
    .i_chan_reset(o_chan_reset), .i_slow(slow), .o_move_done(move_done));

  initial
  begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  task automatic test_done;
    $display("Checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Outputs are sampled 1 ns after the taking edge, while the one-cycle pulses stand.
  task automatic send(input cmd_code_type c, input logic a, input logic [11:0] v);
    @(posedge i_ref_clk);
    i_cmd_valid <= 1'b1;
    i_cmd <= '{code: c, arg: a, value: v};
    @(posedge i_ref_clk);
    i_cmd_valid <= 1'b0;
    #1;
  endtask

  task automatic strobe(input int k);
    @(posedge i_ref_clk);
    i_syntax_err <= (k == 0);
    i_talk_addr <= (k == 1);
    i_spoll_read <= (k == 2);
    @(posedge i_ref_clk);
    {i_syntax_err, i_talk_addr, i_spoll_read} <= 3'b000;
    #1;
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (o_status.busy !== 1'b0 && n < 100)
    begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    if (n >= 100)
    begin
      bad_count++;
      $display("[ERR] busy expected 0 seen %b", o_status.busy);
      test_done;
    end
  endtask

  initial
  begin
    {i_rst, i_cmd_valid, i_syntax_err, i_talk_addr, i_spoll_read, slow} = 6'h20;
    i_cmd = '0;
    err_a = 4'h0;
    err_b = 4'h0;
    bad_count = 0;
    comparisons = 0;
    rows = '{'{CMD_EMU_ENTRY, 1'b0, 8'h20, 1'b1}, '{CMD_CHAN_B, 1'b0, 8'hA0, 1'b1},
             '{CMD_CHAN_A, 1'b0, 8'h20, 1'b1}, '{CMD_NATIVE, 1'b0, 8'h00, 1'b0},
             '{CMD_CHAN_B, 1'b0, 8'h00, 1'b0}, '{CMD_LEARN, 1'b0, 8'h20, 1'b1},
             '{CMD_NATIVE, 1'b0, 8'h00, 1'b0}, '{CMD_RECALL, 1'b0, 8'h20, 1'b1},
             '{CMD_READY_CTL, 1'b1, 8'h20, 1'b1}, '{CMD_ERROR_CTL, 1'b0, 8'h20, 1'b1}};
    repeat (20) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    #1;
    chk("reset status", 12'h000, {4'h0, o_status});
    foreach (rows[i])
    begin
      send(rows[i].code, rows[i].arg, 12'h000);
      chk("row status", {4'h0, rows[i].st}, {4'h0, o_status});
      chk("row mode", {11'h0, rows[i].emu}, {11'h0, o_emu_mode});
    end
    $display("Table done");
    send(CMD_VALUE_SEL, 1'b0, 12'h064);
    send(CMD_SET, 1'b0, 12'h000);
    chk("move value", 12'h064, o_move_value);
    chk("move req", 12'h001, {11'h0, o_move_req});
    chk("busy status", 12'h010, {4'h0, o_status});
    wait_idle;
    chk("ready srq status", 12'h060, {4'h0, o_status});
    chk("srq line", 12'h001, {11'h0, o_srq});
    strobe(2);
    chk("polled status", 12'h020, {4'h0, o_status});
    strobe(1);
    chk("talk value", 12'h064, o_talk_value);
    chk("talk valid", 12'h001, {11'h0, o_talk_valid});
    $display("Move done");
    slow = 1'b1;
    send(CMD_CHAN_B, 1'b0, 12'h000);
    send(CMD_DEC, 1'b0, 12'h000);
    chk("dec wrap", `SET_MAX, o_move_value);
    chk("move chan", 12'h001, {11'h0, o_move_chan});
    send(CMD_CHAN_A, 1'b0, 12'h000);
    chk("busy refuse", 12'h090, {4'h0, o_status});
    wait_idle;
    chk("b ready srq", 12'h0E0, {4'h0, o_status});
    strobe(2);
    slow = 1'b0;
    send(CMD_INC, 1'b0, 12'h000);
    chk("inc wrap", 12'h000, o_move_value);
    wait_idle;
    strobe(2);
    $display("Wrap done");
    send(CMD_RESET, 1'b0, 12'h000);
    chk("reset start", 12'h001, {11'h0, o_chan_reset});
    wait_idle;
    send(CMD_VALUE_SEL, 1'b0, `SET_MAX + 12'h001);
    send(CMD_SET, 1'b0, 12'h000);
    chk("range reset", 12'h001, {11'h0, o_chan_reset});
    wait_idle;
    strobe(2);
    send(CMD_READY_CTL, 1'b0, 12'h000);
    send(CMD_ERROR_CTL, 1'b1, 12'h000);
    @(posedge i_ref_clk);
    err_b <= 4'h3;
    repeat (2) @(posedge i_ref_clk);
    #1;
    chk("error srq", 12'h0E3, {4'h0, o_status});
    strobe(2);
    send(CMD_INC, 1'b0, 12'h000);
    wait_idle;
    chk("no ready srq", 12'h0A3, {4'h0, o_status});
    send(CMD_CHAN_A, 1'b0, 12'h000);
    chk("chan a error", 12'h020, {4'h0, o_status});
    send(CMD_ERROR_CTL, 1'b0, 12'h000);
    send(CMD_CHAN_B, 1'b0, 12'h000);
    repeat (2) @(posedge i_ref_clk);
    #1;
    chk("error srq off", 12'h0A3, {4'h0, o_status});
    send(CMD_ERROR_CTL, 1'b1, 12'h000);
    @(posedge i_ref_clk);
    err_b <= 4'h0;
    @(posedge i_ref_clk);
    err_b <= 4'h5;
    i_spoll_read <= 1'b1;
    @(posedge i_ref_clk);
    i_spoll_read <= 1'b0;
    #1;
    chk("set beats clear", 12'h0E5, {4'h0, o_status});
    $display("Request done");
    strobe(0);
    chk("flush", 12'h001, {11'h0, o_flush});
    send(CMD_NATIVE, 1'b0, 12'h000);
    strobe(0);
    chk("native flush", 12'h000, {11'h0, o_flush});
    $display("Flush done");
    send(CMD_EMU_ENTRY, 1'b0, 12'h000);
    chk("srq before reset", 12'h001, {11'h0, o_srq});
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    #1;
    chk("mid reset status", 12'h000, {4'h0, o_status});
    chk("mid reset srq", 12'h000, {11'h0, o_srq});
    chk("mid reset mode", 12'h000, {11'h0, o_emu_mode});
    send(CMD_EMU_ENTRY, 1'b0, 12'h000);
    chk("entry after reset", 12'h020, {4'h0, o_status});
    $display("Reset done");
    test_done;
  end
endmodule
`default_nettype wire
